/* File: sfis_params.svh */
// timing counts, bit widths and command codes for the interface sequencer
// assumes inclusion by the sequencer module, its checker and the bench top
`ifndef SFIS_PARAMS_SVH
`define SFIS_PARAMS_SVH

`define SFIS_INSTR_BITS        8
`define SFIS_LAT_CODE_W        4
`define SFIS_ADDR_BITS         24
`define SFIS_MODE_BITS         8
`define SFIS_DATA_BYTE         8
`define SFIS_CLK_PERIOD_NS     20
// command codes (arbitrary defaults, fixed here, not parameters)
`define SFIS_CMD_READ          8'h03
`define SFIS_CMD_FAST_READ     8'h0b
`define SFIS_CMD_DUAL_OUT      8'h3b
`define SFIS_CMD_QUAD_OUT      8'h6b
`define SFIS_CMD_DUAL_IO       8'hbb
`define SFIS_CMD_QUAD_IO       8'heb
`define SFIS_CMD_DDR_QUAD_IO   8'hed
`define SFIS_CMD_PAGE_PROG     8'h02
`define SFIS_CMD_QUAD_PROG     8'h32
`define SFIS_CMD_WR_STAT_CFG   8'h01
`define SFIS_CMD_WR_ANY_REG    8'h71
`define SFIS_CMD_WR_LEARN      8'h43
`define SFIS_CMD_WR_LEARN_V    8'h4a

`endif

/* File: sfis_pkg.sv */
// types shared by the interface sequencer
// assumes sfis_params.svh sits in the same folder
package sfis_pkg;
   typedef enum logic [3:0]
   {
      SFIS_STANDBY  = 4'h0,
      SFIS_INSTR    = 4'h1,
      SFIS_ADDR     = 4'h2,
      SFIS_MODE     = 4'h3,
      SFIS_LATENCY  = 4'h4,
      SFIS_DATA_IN  = 4'h5,
      SFIS_DATA_OUT = 4'h6,
      SFIS_DONE     = 4'h7
   } sfis_state_t;

   typedef enum logic [2:0]
   {
      SFIS_FMT_NONE   = 3'h0,
      SFIS_FMT_SINGLE = 3'h1,
      SFIS_FMT_DUAL_O = 3'h2,
      SFIS_FMT_QUAD_O = 3'h3,
      SFIS_FMT_DUAL_IO = 3'h4,
      SFIS_FMT_QUAD_IO = 3'h5,
      SFIS_FMT_DDR_QIO = 3'h6,
      SFIS_FMT_QPROG  = 3'h7
   } sfis_fmt_t;

   // lane width code: number of lanes used per link cycle
   typedef enum logic [1:0]
   {
      SFIS_W1 = 2'h0,
      SFIS_W2 = 2'h1,
      SFIS_W4 = 2'h2
   } sfis_width_t;
endpackage

/* File: sfis_sync.sv */
// two-flop synchroniser for a bundle of pin levels
// assumes the pins are asynchronous to i_clk
`timescale 1ns/1ns
module sfis_sync
#(
   parameter int W = 1
)
(
   // clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   // level in and out
   input  wire logic [W-1:0] i_async,
   input  wire logic [W-1:0] i_rst_val,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] stage1;
   logic [W-1:0] stage2;

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         stage1 <= '1;
         stage2 <= '1;
      end
      else
      begin
         stage1 <= i_async;
         stage2 <= stage1;
      end
   end

   assign o_sync = stage2;
endmodule

/* File: sfis_sequencer.sv */
// interface-state sequencer of a multi-lane serial flash, device side
// assumes host drives chip select, serial clock and data lanes (mode 0);
// every pin is sampled by i_clk through two flops before use
`timescale 1ns/1ns
`include "sfis_params.svh"
module sfis_sequencer
   import sfis_pkg::*;
#(
   parameter int ADDR_BITS = `SFIS_ADDR_BITS,
   parameter int MODE_BITS = `SFIS_MODE_BITS
)
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   // link pins
   input  wire logic        i_cs_n,
   input  wire logic        i_sck,
   input  wire logic [3:0]  i_io,
   output logic      [3:0]  o_io,
   output logic      [3:0]  o_io_oe,
   input  wire logic        i_wp_n,
   // configuration held elsewhere in the device
   input  wire logic        i_quad_enable,
   input  wire logic        i_quad_peripheral_mode,
   input  wire logic [3:0]  i_volatile_config_three,
   // read data source
   input  wire logic [7:0]  i_rd_data,
   output logic             o_rd_next,
   // received stream
   output logic [7:0]       o_instr,
   output logic             o_instr_valid,
   output logic [31:0]      o_addr,
   output logic             o_addr_valid,
   output logic [7:0]       o_wr_data,
   output logic             o_wr_valid,
   output logic             o_wp_sampled,
   output sfis_fmt_t        o_format,
   output sfis_state_t      o_state,
   output logic             o_cmd_end
);
   // ==========================================================
   // pin synchronisation
   // ==========================================================
   logic [6:0] pins_sync;
   logic       cs_n_s;
   logic       sck_s;
   logic [3:0] io_s;
   logic       wp_n_s;
   logic       sck_d;
   logic       sck_rise;
   logic       sck_fall;
   logic       cs_n_d;
   logic       cs_rise;

   sfis_sync #(.W(7)) u_sync
   (
      .i_clk     (i_clk),
      .i_rst_n   (i_rst_n),
      .i_async   ({i_wp_n, i_io, i_sck, i_cs_n}),
      .i_rst_val (7'h7f),
      .o_sync    (pins_sync)
   );

   assign cs_n_s = pins_sync[0];
   assign sck_s  = pins_sync[1];
   assign io_s   = pins_sync[5:2];
   assign wp_n_s = pins_sync[6];

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sck_d  <= 1'b0;
         cs_n_d <= 1'b1;
      end
      else
      begin
         sck_d  <= sck_s;
         cs_n_d <= cs_n_s;
      end
   end

   // edges only count while selected
   assign sck_rise = !cs_n_s && sck_s && !sck_d;
   assign sck_fall = !cs_n_s && !sck_s && sck_d;
   assign cs_rise  = cs_n_s && !cs_n_d;

   // ==========================================================
   // state and counters
   // ==========================================================
   sfis_state_t state;
   sfis_state_t next_state;
   sfis_width_t width;
   sfis_width_t next_width;
   sfis_fmt_t   fmt;
   logic [5:0]  cnt;
   logic [7:0]  shreg;
   logic [7:0]  next_shreg;
   logic [3:0]  lat_code;
   logic        fast_read;
   logic        end_phase;
   logic [5:0]  step;
   logic [5:0]  phase_bits;

   // bits taken per rising edge
   always_comb
   begin
      unique case (width)
         SFIS_W1: step = 6'd1;
         SFIS_W2: step = 6'd2;
         SFIS_W4: step = 6'd4;
         default: step = 6'd1;
      endcase
   end

   always_comb
   begin
      unique case (state)
         SFIS_INSTR:   phase_bits = 6'(`SFIS_INSTR_BITS);
         SFIS_ADDR:    phase_bits = 6'(ADDR_BITS);
         SFIS_MODE:    phase_bits = 6'(MODE_BITS);
         SFIS_LATENCY: phase_bits = {2'h0, lat_code};
         default:      phase_bits = 6'(`SFIS_DATA_BYTE);
      endcase
   end

   // latency counts cycles, other phases count bits
   assign end_phase = (state == SFIS_LATENCY) ?
                      (cnt + 6'd1 >= phase_bits) :
                      (cnt + step >= phase_bits);

   // shift in lanes for current width
   always_comb
   begin
      unique case (width)
         SFIS_W1: next_shreg = {shreg[6:0], io_s[0]};
         SFIS_W2: next_shreg = {shreg[5:0], io_s[1:0]};
         SFIS_W4: next_shreg = {shreg[3:0], io_s};
         default: next_shreg = shreg;
      endcase
   end

   // decode of the instruction just completed
   sfis_fmt_t   dec_fmt;
   logic [7:0]  dec_op;
   assign dec_op = next_shreg;

   always_comb
   begin
      unique case (dec_op)
         `SFIS_CMD_READ,
         `SFIS_CMD_FAST_READ,
         `SFIS_CMD_PAGE_PROG,
         `SFIS_CMD_WR_STAT_CFG,
         `SFIS_CMD_WR_ANY_REG,
         `SFIS_CMD_WR_LEARN,
         `SFIS_CMD_WR_LEARN_V: dec_fmt = SFIS_FMT_SINGLE;
         `SFIS_CMD_DUAL_OUT:   dec_fmt = SFIS_FMT_DUAL_O;
         `SFIS_CMD_QUAD_OUT:   dec_fmt = SFIS_FMT_QUAD_O;
         `SFIS_CMD_DUAL_IO:    dec_fmt = SFIS_FMT_DUAL_IO;
         `SFIS_CMD_QUAD_IO:    dec_fmt = SFIS_FMT_QUAD_IO;
         `SFIS_CMD_DDR_QUAD_IO: dec_fmt = SFIS_FMT_DDR_QIO;
         `SFIS_CMD_QUAD_PROG:  dec_fmt = SFIS_FMT_QPROG;
         default:              dec_fmt = SFIS_FMT_NONE;
      endcase
   end

   logic is_write_op;
   logic is_reg_write;
   assign is_reg_write = (dec_op == `SFIS_CMD_WR_STAT_CFG) ||
                         (dec_op == `SFIS_CMD_WR_ANY_REG) ||
                         (dec_op == `SFIS_CMD_WR_LEARN) ||
                         (dec_op == `SFIS_CMD_WR_LEARN_V);
   assign is_write_op  = is_reg_write ||
                         (dec_op == `SFIS_CMD_PAGE_PROG) ||
                         (dec_op == `SFIS_CMD_QUAD_PROG);

   // where the phase after the address leads
   sfis_state_t after_addr;
   always_comb
   begin
      if (fmt == SFIS_FMT_QPROG || fmt == SFIS_FMT_SINGLE && !fast_read
          && o_instr != `SFIS_CMD_READ)
         after_addr = SFIS_DATA_IN;
      else if (fmt == SFIS_FMT_DUAL_IO || fmt == SFIS_FMT_QUAD_IO)
         after_addr = SFIS_MODE;
      else if (lat_code != 4'h0 && o_instr != `SFIS_CMD_READ)
         after_addr = SFIS_LATENCY;
      else
         after_addr = SFIS_DATA_OUT;
   end

   // lane width of the output phase
   sfis_width_t out_width;
   always_comb
   begin
      unique case (fmt)
         SFIS_FMT_DUAL_O,
         SFIS_FMT_DUAL_IO: out_width = SFIS_W2;
         SFIS_FMT_QUAD_O,
         SFIS_FMT_QUAD_IO,
         SFIS_FMT_DDR_QIO: out_width = SFIS_W4;
         default:          out_width = i_quad_peripheral_mode ?
                                       SFIS_W4 : SFIS_W1;
      endcase
   end

   always_comb
   begin
      next_state = state;
      next_width = width;
      unique case (state)
         SFIS_STANDBY:
         begin
            if (!cs_n_s)
            begin
               next_state = SFIS_INSTR;
               next_width = i_quad_peripheral_mode ? SFIS_W4 : SFIS_W1;
            end
         end
         SFIS_INSTR:
         begin
            if (sck_rise && end_phase)
            begin
               if (!is_write_op && dec_fmt == SFIS_FMT_NONE)
                  next_state = SFIS_DONE;
               else if (is_reg_write)
                  next_state = SFIS_DATA_IN;
               else
               begin
                  next_state = SFIS_ADDR;
                  unique case (dec_fmt)
                     SFIS_FMT_DUAL_IO: next_width = SFIS_W2;
                     SFIS_FMT_QUAD_IO,
                     SFIS_FMT_DDR_QIO: next_width = SFIS_W4;
                     SFIS_FMT_QPROG,
                     SFIS_FMT_QUAD_O:  next_width =
                        i_quad_peripheral_mode ? SFIS_W4 : SFIS_W1;
                     default:          next_width =
                        i_quad_peripheral_mode ? SFIS_W4 : SFIS_W1;
                  endcase
               end
            end
         end
         SFIS_ADDR:
         begin
            if (sck_rise && end_phase)
            begin
               next_state = after_addr;
               if (after_addr == SFIS_DATA_IN)
                  next_width = (fmt == SFIS_FMT_QPROG ||
                     i_quad_peripheral_mode) ? SFIS_W4 : SFIS_W1;
               else if (after_addr == SFIS_DATA_OUT)
                  next_width = out_width;
            end
         end
         SFIS_MODE:
         begin
            if (sck_rise && end_phase)
            begin
               next_state = (lat_code != 4'h0) ? SFIS_LATENCY
                                               : SFIS_DATA_OUT;
               next_width = out_width;
            end
         end
         SFIS_LATENCY:
         begin
            if (sck_rise && end_phase)
            begin
               next_state = SFIS_DATA_OUT;
               next_width = out_width;
            end
         end
         SFIS_DATA_IN:  next_state = state;
         SFIS_DATA_OUT: next_state = state;
         SFIS_DONE:     next_state = state;
         default:       next_state = SFIS_STANDBY;
      endcase
      if (cs_n_s)
      begin
         next_state = SFIS_STANDBY;
         next_width = SFIS_W1;
      end
   end

   // ==========================================================
   // state registers
   // ==========================================================
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state <= SFIS_STANDBY;
         width <= SFIS_W1;
      end
      else
      begin
         state <= next_state;
         width <= next_width;
      end
   end

   // bit counter restarts on every phase change
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         cnt <= 6'h0;
      else if (next_state != state || cs_n_s)
         cnt <= 6'h0;
      else if (sck_rise)
         cnt <= (state == SFIS_LATENCY) ? cnt + 6'd1 : cnt + step;
   end

   // ==========================================================
   // input capture
   // ==========================================================
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         shreg         <= 8'h00;
         o_instr       <= 8'h00;
         o_instr_valid <= 1'b0;
         o_addr        <= 32'h0;
         o_addr_valid  <= 1'b0;
         o_wr_data     <= 8'h00;
         o_wr_valid    <= 1'b0;
         fmt           <= SFIS_FMT_NONE;
         fast_read     <= 1'b0;
         lat_code      <= 4'h0;
      end
      else
      begin
         o_instr_valid <= 1'b0;
         o_addr_valid  <= 1'b0;
         o_wr_valid    <= 1'b0;
         if (state == SFIS_STANDBY && !cs_n_s)
            lat_code <= i_volatile_config_three;
         // latency and output phases leave inputs unread
         if (sck_rise && (state == SFIS_INSTR || state == SFIS_ADDR ||
             state == SFIS_MODE || state == SFIS_DATA_IN))
         begin
            shreg <= next_shreg;
            if (state == SFIS_ADDR)
            begin
               unique case (width)
                  SFIS_W2: o_addr <= {o_addr[29:0], io_s[1:0]};
                  SFIS_W4: o_addr <= {o_addr[27:0], io_s};
                  default: o_addr <= {o_addr[30:0], io_s[0]};
               endcase
            end
            if (end_phase && state == SFIS_INSTR)
            begin
               o_instr       <= next_shreg;
               o_instr_valid <= 1'b1;
               fmt           <= dec_fmt;
               fast_read     <= (next_shreg == `SFIS_CMD_FAST_READ);
            end
            if (end_phase && state == SFIS_ADDR)
               o_addr_valid <= 1'b1;
            if (end_phase && state == SFIS_DATA_IN)
            begin
               o_wr_data  <= next_shreg;
               o_wr_valid <= 1'b1;
            end
         end
         if (state == SFIS_STANDBY)
            o_addr <= 32'h0;
      end
   end

   // write-protect caught once, in register-write instruction cycles
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_wp_sampled <= 1'b1;
      else if (state == SFIS_INSTR && sck_rise && end_phase && is_reg_write)
         o_wp_sampled <= wp_n_s;
   end

   // ==========================================================
   // output drive
   // ==========================================================
   logic [7:0] out_sh;
   logic [3:0] out_lanes;
   logic [3:0] out_en;
   logic [2:0] out_bit;
   logic       out_first;

   always_comb
   begin
      unique case (width)
         SFIS_W2: out_en = 4'h3;
         SFIS_W4: out_en = 4'hf;
         default: out_en = 4'h2;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         out_sh    <= 8'h00;
         out_bit   <= 3'h0;
         out_first <= 1'b1;
         out_lanes <= 4'h0;
         o_io_oe   <= 4'h0;
         o_rd_next <= 1'b0;
      end
      else
      begin
         o_rd_next <= 1'b0;
         if (state != SFIS_DATA_OUT || cs_n_s)
         begin
            o_io_oe   <= 4'h0;
            out_first <= 1'b1;
            out_bit   <= 3'h0;
         end
         else if (sck_fall)
         begin
            if (out_bit == 3'h0)
            begin
               out_sh    <= i_rd_data;
               o_rd_next <= 1'b1;
            end
            unique case (width)
               SFIS_W2: out_lanes <= {2'h0,
                  (out_bit == 3'h0) ? i_rd_data[7:6] : out_sh[7:6]};
               SFIS_W4: out_lanes <=
                  (out_bit == 3'h0) ? i_rd_data[7:4] : out_sh[7:4];
               default: out_lanes <= {2'h0,
                  (out_bit == 3'h0) ? i_rd_data[7] : out_sh[7], 1'b0};
            endcase
            if (out_bit != 3'h0)
               out_sh <= out_sh << ((width == SFIS_W4) ? 4 :
                                    (width == SFIS_W2) ? 2 : 1);
            else
               out_sh <= i_rd_data << ((width == SFIS_W4) ? 4 :
                                       (width == SFIS_W2) ? 2 : 1);
            out_bit   <= out_bit + ((width == SFIS_W4) ? 3'd4 :
                                    (width == SFIS_W2) ? 3'd2 : 3'd1);
            o_io_oe   <= out_en;
            out_first <= 1'b0;
         end
      end
   end

   assign o_io      = out_lanes;
   assign o_format  = fmt;
   assign o_state   = state;
   assign o_cmd_end = cs_rise;
endmodule

/* File: sfis_sequencer_asserts.sv */
// port checker for the interface sequencer
// assumes binding onto sfis_sequencer, single clock domain
`timescale 1ns/1ns
`include "sfis_params.svh"
module sfis_sequencer_asserts
   import sfis_pkg::*;
(
   // clock and reset
   input wire logic        i_clk,
   input wire logic        i_rst_n,
   // watched ports
   input wire logic        i_cs_n,
   input wire logic [3:0]  o_io_oe,
   input wire logic [7:0]  o_instr,
   input wire logic        o_wp_sampled,
   input wire sfis_fmt_t   o_format,
   input wire sfis_state_t o_state
);
   // ====================
   // properties
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   property p_standby_state;
      i_cs_n [*6] |-> o_state == SFIS_STANDBY;
   endproperty
   a_standby_state: assert property (p_standby_state)
      else $error("state not standby while deselected");

   property p_standby_float;
      i_cs_n [*6] |-> o_io_oe == 4'h0;
   endproperty
   a_standby_float: assert property (p_standby_float)
      else $error("lanes driven while deselected");

   property p_start_instr;
      $fell(i_cs_n) |-> ##[1:6] o_state == SFIS_INSTR;
   endproperty
   a_start_instr: assert property (p_start_instr)
      else $error("no instruction phase after select");

   property p_input_float;
      o_state inside {SFIS_INSTR, SFIS_ADDR, SFIS_MODE, SFIS_DATA_IN}
         |-> o_io_oe == 4'h0;
   endproperty
   a_input_float: assert property (p_input_float)
      else $error("lanes driven in an input phase");

   property p_latency_float;
      o_state == SFIS_LATENCY |-> o_io_oe == 4'h0;
   endproperty
   a_latency_float: assert property (p_latency_float)
      else $error("lanes driven in latency");

   property p_single_lane;
      o_state == SFIS_DATA_OUT && o_format == SFIS_FMT_SINGLE
         |-> o_io_oe inside {4'h0, 4'h2};
   endproperty
   a_single_lane: assert property (p_single_lane)
      else $error("single output on wrong lane");

   property p_dual_lanes;
      o_state == SFIS_DATA_OUT
         && o_format inside {SFIS_FMT_DUAL_O, SFIS_FMT_DUAL_IO}
         |-> o_io_oe inside {4'h0, 4'h3};
   endproperty
   a_dual_lanes: assert property (p_dual_lanes)
      else $error("dual output on wrong lanes");

   property p_quad_lanes;
      o_state == SFIS_DATA_OUT
         && o_format inside {SFIS_FMT_QUAD_O, SFIS_FMT_QUAD_IO}
         |-> o_io_oe inside {4'h0, 4'hf};
   endproperty
   a_quad_lanes: assert property (p_quad_lanes)
      else $error("quad output on wrong lanes");

   property p_wp_window;
      $changed(o_wp_sampled) |-> ##[0:4] o_instr inside
         {`SFIS_CMD_WR_STAT_CFG, `SFIS_CMD_WR_ANY_REG,
          `SFIS_CMD_WR_LEARN, `SFIS_CMD_WR_LEARN_V};
   endproperty
   a_wp_window: assert property (p_wp_window)
      else $error("write protect caught outside register write");
endmodule

bind sfis_sequencer sfis_sequencer_asserts sfis_sequencer_asserts_i
(
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n),
   .o_io_oe(o_io_oe), .o_instr(o_instr), .o_wp_sampled(o_wp_sampled),
   .o_format(o_format), .o_state(o_state)
);

/* File: sfis_host_model.sv */
// host side of the link: chip select, serial clock and lanes, mode 0
// assumes a 50 MHz i_clk; tasks are called from the bench top
`timescale 1ns/1ns
module sfis_host_model
(
   // clock
   input  wire logic       i_clk,
   // device modes seen by the host
   input  wire logic       i_qe,
   input  wire logic       i_qpi,
   // link pins
   input  wire logic [3:0] i_io,
   output logic            o_cs_n,
   output logic            o_sck,
   output logic [3:0]      o_io,
   output logic [3:0]      o_io_oe
);
   logic       hold3;
   logic [3:0] drv;
   logic [3:0] en;

   // lane three held high outside quad modes
   assign hold3   = !i_qe && !i_qpi;
   assign o_io    = hold3 ? {1'b1, drv[2:0]} : drv;
   assign o_io_oe = hold3 ? {1'b1, en[2:0]} : en;

   initial
   begin
      o_cs_n = 1'b1;
      o_sck  = 1'b0;
      drv    = 4'h0;
      en     = 4'h0;
   end

   // select level change, always with sck parked low
   task automatic sel(input logic lvl);
      @(posedge i_clk);
      o_sck <= 1'b0;
      repeat (4) @(posedge i_clk);
      o_cs_n <= lvl;
      en     <= 4'h0;
      repeat (8) @(posedge i_clk);
   endtask

   // n bits, w lanes a cycle; listening releases every lane except a held lane three
   task automatic xfer(input logic [31:0] d, input int n, input int w,
                       input logic listen, output logic [31:0] q);
      logic [3:0] m;
      m = 4'((1 << w) - 1);
      q = 32'h0;
      for (int i = 0; i < n; i += w)
      begin
         @(posedge i_clk);
         o_sck <= 1'b0;
         drv   <= 4'(d >> (n - w - i)) & m;
         en    <= listen ? 4'h0 : m;
         repeat (4) @(posedge i_clk);
         o_sck <= 1'b1;
         repeat (3) @(posedge i_clk);
         q = (q << w) | 32'((w == 1) ? {3'h0, i_io[1]} : i_io & m);
      end
   endtask
endmodule

/* File: sfis_sequencer_tb_top.sv */
// self-checking bench for the interface sequencer
// assumes sequencer, checker and host model are compiled before it
`timescale 1ns/1ns
`include "sfis_params.svh"
module sfis_sequencer_tb_top
   import sfis_pkg::*;
   ;
   logic        clk      = 1'b0;
   logic        rst_n    = 1'b0;
   logic        wp_n     = 1'b1;
   logic        qe       = 1'b0;
   logic        quad_peripheral_mode      = 1'b0;
   logic        flt      = 1'b0;
   logic [3:0]  lat_code = 4'h0;
   logic [7:0]  rd_src   = 8'ha5;
   logic [7:0]  got_i    = 8'h0;
   logic [7:0]  got_w    = 8'h0;
   logic [31:0] got_a    = 32'h0;
   logic        cs_n, sck, rd_next, instr_v, addr_v, wr_v, wp_s;
   logic        cmd_end;
   int          n_end    = 0;
   logic [3:0]  h_io, h_oe, d_io, d_oe, io_w;
   logic [7:0]  instr, wr_data;
   logic [31:0] addr, q;
   sfis_fmt_t   fmt;
   sfis_state_t state;
   int          n_fail;
   int          compares;

   initial
   begin
      forever #10 clk = ~clk;
   end

   // ====================
   // lane resolution and read source
   always @(negedge clk) flt <= !flt;
   always_comb
      for (int k = 0; k < 4; k++)
         io_w[k] = d_oe[k] ? d_io[k] : h_oe[k] ? h_io[k] : flt ^ k[0];

   always @(posedge clk)
   begin
      if (rd_next) rd_src <= rd_src + 8'h11;
      if (instr_v) got_i <= instr;
      if (addr_v) got_a <= addr;
      if (wr_v) got_w <= wr_data;
      if (cmd_end) n_end++;
   end

   sfis_sequencer sfis_sequencer_i
   (
      .i_clk(clk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_sck(sck),
      .i_io(io_w), .o_io(d_io), .o_io_oe(d_oe), .i_wp_n(wp_n),
      .i_quad_enable(qe), .i_quad_peripheral_mode(quad_peripheral_mode),
      .i_volatile_config_three(lat_code), .i_rd_data(rd_src),
      .o_rd_next(rd_next), .o_instr(instr), .o_instr_valid(instr_v),
      .o_addr(addr), .o_addr_valid(addr_v), .o_wr_data(wr_data),
      .o_wr_valid(wr_v), .o_wp_sampled(wp_s), .o_format(fmt),
      .o_state(state), .o_cmd_end(cmd_end)
   );

   sfis_host_model sfis_host_model_i
   (
      .i_clk(clk), .i_qe(qe), .i_qpi(quad_peripheral_mode), .i_io(io_w),
      .o_cs_n(cs_n), .o_sck(sck), .o_io(h_io), .o_io_oe(h_oe)
   );

   // ====================
   // shared tasks
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic send(input logic [7:0] ins);
      sfis_host_model_i.sel(1'b0);
      sfis_host_model_i.xfer(32'(ins), 8, 1, 1'b0, q);
      sfis_host_model_i.sel(1'b1);
   endtask

   task automatic rd(input logic [7:0] ins, input int aw, input int mw,
                     input logic [3:0] lc, input int dw, input sfis_fmt_t f);
      lat_code <= lc;
      rd_src   <= 8'ha5;
      sfis_host_model_i.sel(1'b0);
      sfis_host_model_i.xfer(32'(ins), 8, 1, 1'b0, q);
      sfis_host_model_i.xfer(32'h00123456, 24, aw, 1'b0, q);
      if (mw > 0)
         sfis_host_model_i.xfer(32'h0, 8, mw, 1'b0, q);
      if (lc > 0)
         sfis_host_model_i.xfer(32'h0, int'(lc), 1, 1'b1, q);
      sfis_host_model_i.xfer(32'h0, 16, dw, 1'b1, q);
      chk("format", 32'(fmt), 32'(f));
      sfis_host_model_i.sel(1'b1);
      chk("address", got_a, 32'h00123456);
      chk("read data", q, 32'h0000a5b6);
   endtask

   // ====================
   // scenarios
   task automatic t_standalone();
      send(8'h06);
      chk("instruction", 32'(got_i), 32'h06);
      chk("state", 32'(state), 32'(SFIS_STANDBY));
      sfis_host_model_i.xfer(32'h03, 8, 1, 1'b0, q);
      sfis_host_model_i.sel(1'b1);
      chk("deselected instruction", 32'(got_i), 32'h06);
      $display("test standalone done");
   endtask

   task automatic t_wp();
      logic [7:0] c [4];
      c = '{`SFIS_CMD_WR_STAT_CFG, `SFIS_CMD_WR_ANY_REG,
            `SFIS_CMD_WR_LEARN, `SFIS_CMD_WR_LEARN_V};
      for (int k = 0; k < 4; k++)
      begin
         wp_n <= k[0];
         send(c[k]);
         chk("wp sampled", 32'(wp_s), 32'(k[0]));
         wp_n <= !k[0];
         send(`SFIS_CMD_READ);
         chk("wp kept", 32'(wp_s), 32'(k[0]));
      end
      $display("test write protect done");
   endtask

   task automatic t_narrow();
      rd(`SFIS_CMD_FAST_READ, 1, 0, 4'h3, 1, SFIS_FMT_SINGLE);
      rd(`SFIS_CMD_DUAL_IO, 2, 2, 4'h0, 2, SFIS_FMT_DUAL_IO);
      rd(`SFIS_CMD_DUAL_OUT, 1, 0, 4'h1, 2, SFIS_FMT_DUAL_O);
      $display("test single and dual reads done");
   endtask

   task automatic t_abort();
      int e0;
      lat_code <= 4'h0;
      sfis_host_model_i.sel(1'b0);
      sfis_host_model_i.xfer(32'(`SFIS_CMD_READ), 8, 1, 1'b0, q);
      sfis_host_model_i.xfer(32'h0, 27, 1, 1'b1, q);
      chk("output lane", 32'(d_oe), 32'h2);
      e0 = n_end;
      sfis_host_model_i.sel(1'b1);
      chk("command end pulses", 32'(n_end - e0), 32'h1);
      chk("lanes after abort", 32'(d_oe), 32'h0);
      chk("state after abort", 32'(state), 32'(SFIS_STANDBY));
      $display("test abort done");
   endtask

   task automatic t_quad();
      qe <= 1'b1;
      rd(`SFIS_CMD_QUAD_OUT, 1, 0, 4'h2, 4, SFIS_FMT_QUAD_O);
      rd(`SFIS_CMD_QUAD_IO, 4, 4, 4'h1, 4, SFIS_FMT_QUAD_IO);
      quad_peripheral_mode <= 1'b1;
      sfis_host_model_i.sel(1'b0);
      sfis_host_model_i.xfer(32'(`SFIS_CMD_QUAD_PROG), 8, 4, 1'b0, q);
      sfis_host_model_i.xfer(32'h00000100, 24, 4, 1'b0, q);
      sfis_host_model_i.xfer(32'h3c, 8, 4, 1'b0, q);
      sfis_host_model_i.sel(1'b1);
      chk("qpi instruction", 32'(got_i), 32'(`SFIS_CMD_QUAD_PROG));
      chk("program address", got_a, 32'h00000100);
      chk("program data", 32'(got_w), 32'h3c);
      $display("test quad done");
   endtask

   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_standalone();
      t_wp();
      t_narrow();
      t_abort();
      t_quad();
      close_out();
   end

   initial
   begin
      repeat (40000) @(posedge clk);
      n_fail++;
      close_out();
   end
endmodule
